//--- common/hbpwm_pkg.sv
/*
  hbpwm_pkg: register map, field layout, reset values and timing constants
  for the half-bridge dead-band PWM stage.
  assumes: a 100 MHz system clock; the instruction cycle is four clocks.
*/
package hbpwm_pkg;
  // ===========================================================
  // register map, byte addresses on the Avalon-MM word bus
  localparam logic [3:0] HBPWM_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] HBPWM_ADDR_STATUS  = 4'h4;
  localparam int         HBPWM_ADDR_W       = 4;

  // ===========================================================
  // control register fields
  localparam int         HBPWM_RESTART_BIT  = 7;
  localparam int         HBPWM_DELAY_MSB    = 6;
  localparam int         HBPWM_DELAY_W      = 7;
  localparam logic [7:0] HBPWM_CONTROL_RST  = 8'h00;

  // status register fields
  localparam int         HBPWM_SHUTDOWN_BIT = 0;
  localparam int         HBPWM_EVENT_BIT    = 1;

  // ===========================================================
  // timing: one delay unit is one instruction cycle (Fosc/4)
  localparam int         HBPWM_CLK_PER_INSTR = 4;
  localparam int         HBPWM_PRESCALE_W    = 2;
  localparam logic [1:0] HBPWM_PRESCALE_LAST = 2'h3;
endpackage

//--- rtl/hbpwm_deadband.sv
/*
  hbpwm_deadband: dead-band delay for one output edge. after the raw
  request rises, the output stays low for delay instruction cycles.
  assumes: tick is a one-clock pulse once per instruction cycle.
*/
`timescale 1ns/1ps
module hbpwm_deadband #(
  parameter int DELAY_W = 7
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               tick,
  input  wire logic               request,
  input  wire logic [DELAY_W-1:0] delay,
  output logic                    active
);
  logic [DELAY_W-1:0] count_reg;

  // ===========================================================
  // counter: restarts whenever request falls low
  always_ff @(posedge clock) begin
    if (rst || !request) begin
      count_reg <= '0;
    end else if (tick && count_reg < delay) begin
      count_reg <= count_reg + 1'b1;  // see RULE4
    end
  end

  // output held inactive while counting; a delay longer than the active
  // phase means request drops first, so output never goes high
  always_ff @(posedge clock) begin
    if (rst) begin
      active <= 1'b0;
    end else begin
      active <= request && (count_reg >= delay) && !(tick && count_reg < delay); // see RULE2
    end
  end
endmodule

//--- rtl/hbpwm_top.sv
/*
  hbpwm_top: half-bridge PWM output stage with programmable dead band
  and auto-shutdown / restart, registers over Avalon-MM with waitrequest.
  assumes: pwm_in comes from an outside period/duty generator; shutdown_in
  is a synchronous level, high while a shutdown event is present.
*/
// Overview of operation
// RULE1: primary output carries the pwm signal, secondary carries its complement.
// RULE2: seven-bit delay field sets instruction cycles before an output goes active.
// RULE3: delay longer than the active phase keeps that output inactive all period.
// RULE4: one delay unit equals four system clocks, one instruction cycle.
// RULE5: restart enabled: shutdown flag clears itself when the event leaves.
// RULE6: restart disabled: flag stays until software clears it, then output resumes.
// RULE7: software must set both shared pins as outputs in the port logic; here both outputs are dedicated pins with no direction bits.
// RULE8: the output about to go active stays inactive during its delay.
`timescale 1ns/1ps
module hbpwm_top
  import hbpwm_pkg::*;
#(
  parameter int DELAY_W = hbpwm_pkg::HBPWM_DELAY_W
) (
  input  wire logic                               clock,
  input  wire logic                               rst,
  input  wire logic [hbpwm_pkg::HBPWM_ADDR_W-1:0] avs_address,
  input  wire logic                               avs_read,
  input  wire logic                               avs_write,
  input  wire logic [31:0]                        avs_writedata,
  input  wire logic [3:0]                         avs_byteenable,
  output logic      [31:0]                        avs_readdata,
  output logic                                    avs_waitrequest,
  input  wire logic                               pwm_in,
  input  wire logic                               shutdown_in,
  output logic                                    primary_pwm_out,
  output logic                                    complement_pwm_out
);
  import hbpwm_pkg::*;

  initial begin
    if (DELAY_W != HBPWM_DELAY_W) begin
      $error("delay width must match the control register field");
    end
  end

  logic [7:0]                  control_reg;
  logic                        shutdown_event_flag_reg;
  logic [HBPWM_PRESCALE_W-1:0] prescale_reg;
  logic                        tick_reg;
  logic                        served_reg;
  logic                        primary_active;
  logic                        complement_active;
  logic                        run;
  logic                        sw_clear;
  logic                        access;

  // ===========================================================
  // bus slave: one wait state, answer at the second edge
  assign access   = (avs_read || avs_write) && !served_reg;
  // writes commit only at the edge where the master sees waitrequest low
  assign sw_clear = avs_write && !avs_waitrequest && avs_address == HBPWM_ADDR_STATUS
                    && avs_byteenable[0] && !avs_writedata[HBPWM_SHUTDOWN_BIT];

  always_ff @(posedge clock) begin
    if (rst) begin
      served_reg      <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      served_reg      <= access;
      avs_waitrequest <= !access;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      control_reg <= HBPWM_CONTROL_RST;
    end else if (avs_write && !avs_waitrequest && avs_address == HBPWM_ADDR_CONTROL
                 && avs_byteenable[0]) begin
      control_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !served_reg) begin
      unique case (avs_address)
        HBPWM_ADDR_CONTROL: avs_readdata <= {24'h00_0000, control_reg};
        HBPWM_ADDR_STATUS:  avs_readdata <= {30'h0000_0000, shutdown_in,
                                             shutdown_event_flag_reg};
        default:            avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ===========================================================
  // shutdown flag; a present event always wins over any clear
  always_ff @(posedge clock) begin
    if (rst) begin
      shutdown_event_flag_reg <= 1'b0;
    end else if (shutdown_in) begin
      shutdown_event_flag_reg <= 1'b1;
    end else if (control_reg[HBPWM_RESTART_BIT]) begin
      shutdown_event_flag_reg <= 1'b0;  // see RULE5
    end else if (sw_clear) begin
      shutdown_event_flag_reg <= 1'b0;  // see RULE6
    end
  end

  assign run = !shutdown_event_flag_reg && !shutdown_in;

  // ===========================================================
  // instruction-cycle tick
  always_ff @(posedge clock) begin
    if (rst) begin
      prescale_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      prescale_reg <= prescale_reg + 1'b1;
      tick_reg     <= prescale_reg == HBPWM_PRESCALE_LAST;  // see RULE4
    end
  end

  // ===========================================================
  // dead band on each edge; each leg goes low at once, delayed when rising
  hbpwm_deadband #(
    .DELAY_W (DELAY_W)
  ) u_primary (
    .clock   (clock),
    .rst     (rst),
    .tick    (tick_reg),
    .request (pwm_in && run),
    .delay   (control_reg[HBPWM_DELAY_MSB:0]),
    .active  (primary_active)
  );

  hbpwm_deadband #(
    .DELAY_W (DELAY_W)
  ) u_complement (
    .clock   (clock),
    .rst     (rst),
    .tick    (tick_reg),
    .request (!pwm_in && run),  // see RULE1
    .delay   (control_reg[HBPWM_DELAY_MSB:0]),
    .active  (complement_active)
  );

  // pins stay inactive during shutdown and during each dead band
  always_ff @(posedge clock) begin
    if (rst) begin
      primary_pwm_out    <= 1'b0;
      complement_pwm_out <= 1'b0;
    end else begin
      primary_pwm_out    <= primary_active && !complement_active;  // see RULE8
      complement_pwm_out <= complement_active && !primary_active;  // see RULE3
    end
  end
endmodule

//--- test/hbpwm_assertions.sv
/* hbpwm_assertions: port relations of hbpwm_top.
   assumes: bound into hbpwm_top; byte lane 0 always enabled. */
`timescale 1ns/1ps
module hbpwm_assertions (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        pwm_in,
  input wire logic        shutdown_in,
  input wire logic        primary_pwm_out,
  input wire logic        complement_pwm_out
);
  import hbpwm_pkg::*;
  logic [6:0]  dly_reg;
  logic        rsen_reg, held_reg;
  logic [11:0] hi_reg, lo_reg, d4;
  wire         wr = avs_write && !avs_waitrequest;
  assign d4 = {3'h0, dly_reg, 2'h0};
  // ======
  // shadows of control and flag
  always_ff @(posedge clock) begin
    if (rst) {rsen_reg, dly_reg} <= 8'h0;
    else if (wr && avs_address == HBPWM_ADDR_CONTROL) {rsen_reg, dly_reg} <= avs_writedata[7:0];
  end
  always_ff @(posedge clock) begin
    if (rst) held_reg <= 1'h0;
    else if (shutdown_in && !rsen_reg) held_reg <= 1'h1;
    else if (wr && avs_address == HBPWM_ADDR_STATUS && !avs_writedata[0]) held_reg <= 1'h0;
  end
  // 12 bits so the longest low phase never wraps
  always_ff @(posedge clock) begin
    hi_reg <= (rst || !pwm_in) ? 12'h0 : hi_reg + 12'h1;
    lo_reg <= (rst || pwm_in) ? 12'h0 : lo_reg + 12'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence shut_held;
    shutdown_in [*2];
  endsequence
  chk_never_both: assert property (!(primary_pwm_out && complement_pwm_out))
    else $error("both high");
  // free-running tick phase lets a rise come up to one clock before 4*delay
  chk_prim_wait: assert property ($rose(primary_pwm_out) |-> hi_reg + 12'h1 >= d4)
    else $error("primary early");
  chk_comp_wait: assert property ($rose(complement_pwm_out) |-> lo_reg + 12'h1 >= d4)
    else $error("complement early");
  chk_prim_fall: assert property ($fell(pwm_in) |-> ##2 !primary_pwm_out)
    else $error("primary late");
  chk_comp_fall: assert property ($rose(pwm_in) |-> ##2 !complement_pwm_out)
    else $error("complement late");
  chk_shut_quiet: assert property (shut_held |=> !primary_pwm_out && !complement_pwm_out)
    else $error("shutdown leak");
  chk_held_off: assert property (held_reg && !rsen_reg && !shutdown_in |->
    !primary_pwm_out && !complement_pwm_out) else $error("held leak");
endmodule
bind hbpwm_top hbpwm_assertions chk (.*);

//--- test/hbpwm_bridge_model.sv
/* hbpwm_bridge_model: high and low switch drivers of the bridge.
   assumes: gates active high, sampled on the system clock. */
`timescale 1ns/1ps
module hbpwm_bridge_model (
  input  wire logic        clock,
  input  wire logic        high_gate,
  input  wire logic        low_gate,
  output logic      [31:0] shoot_cnt,
  output logic      [31:0] high_cnt
);
  logic high_q = 1'h0;
  initial shoot_cnt = 32'h0;
  initial high_cnt = 32'h0;
  // both switches on would short the rail
  always @(posedge clock) begin
    high_q <= high_gate;
    if (high_gate && low_gate) shoot_cnt <= shoot_cnt + 32'h1;
    if (high_gate && !high_q) high_cnt <= high_cnt + 32'h1;
  end
endmodule

//--- test/tb_top.sv
/* tb_top: bus, pwm and shutdown stimulus with the bridge model.
   assumes: hbpwm_top and the checker bind are compiled. */
`timescale 1ns/1ps
module tb_top;
  import hbpwm_pkg::*;
  typedef struct {logic [7:0] ctl; int hi; int lo;} hbpwm_row_t;
  logic        clock = 0, rst = 1, avs_read = 0, avs_write = 0, pwm_in = 0, shutdown_in = 0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, shoot_cnt, high_cnt;
  logic        avs_waitrequest, primary_pwm_out, complement_pwm_out;
  int          mismatches = 0, num_checks = 0, cyc = 0, pc, cc;
  hbpwm_row_t  rows[4] = '{'{8'h80, 10, 20}, '{8'h03, 40, 50}, '{8'h0a, 36, 60},
                           '{8'h7f, 100, 540}};
  // dedicated pins here, no direction bits to clear
  hbpwm_top dut (.*, .avs_byteenable(4'hf));
  hbpwm_bridge_model bridge (.clock(clock), .high_gate(primary_pwm_out),
    .low_gate(complement_pwm_out), .shoot_cnt(shoot_cnt), .high_cnt(high_cnt));
  always #5 clock = ~clock;
  // ======
  // helpers
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'h0) @(posedge clock);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clock);
  endtask
  function automatic logic fits(int n, int e);
    // tick phase is free-running: a rise may land one clock early or a few late
    return (e <= 0) ? n == 0 : n >= e - 6 && n <= e + 1;
  endfunction
  task automatic shut(input logic [7:0] ctl, input logic [31:0] sts);
    bus(1'h1, HBPWM_ADDR_CONTROL, {24'h0, ctl});
    shutdown_in <= 1'h1;
    repeat (4) @(posedge clock);
    bus(1'h0, HBPWM_ADDR_STATUS, 32'h0);
    chk("sts_on", q, 32'h3);
    shutdown_in <= 1'h0;
    repeat (30) @(posedge clock);
    chk("comp", complement_pwm_out, sts == 32'h0);
    bus(1'h0, HBPWM_ADDR_STATUS, 32'h0);
    chk("sts_off", q, sts);
  endtask
  task automatic test_done;
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    bus(1'h1, 4'h8, 32'hff);
    bus(1'h0, 4'h8, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'h0, HBPWM_ADDR_CONTROL, 32'h0);
    chk("ctl_rst", q, {24'h0, HBPWM_CONTROL_RST});
    foreach (rows[i]) begin
      bus(1'h1, HBPWM_ADDR_CONTROL, {24'h0, rows[i].ctl});
      bus(1'h0, HBPWM_ADDR_CONTROL, 32'h0);
      chk("ctl", q, {24'h0, rows[i].ctl});
      {pc, cc} = 64'h0;
      pwm_in <= 1'h1;
      repeat (rows[i].hi) @(posedge clock) pc += primary_pwm_out;
      pwm_in <= 1'h0;
      repeat (rows[i].lo) @(posedge clock) cc += complement_pwm_out;
      chk("pri_len", fits(pc, rows[i].hi - 4 * rows[i].ctl[6:0]), 1'h1);
      chk("cmp_len", fits(cc, rows[i].lo - 4 * rows[i].ctl[6:0]), 1'h1);
    end
    shut(8'h82, 32'h0);
    shut(8'h02, 32'h1);
    bus(1'h1, HBPWM_ADDR_STATUS, 32'h0);
    repeat (30) @(posedge clock);
    chk("resume", complement_pwm_out, 1'h1);
    chk("shoot", shoot_cnt, 32'h0);
    chk("pulses", high_cnt, 32'h2);
    test_done;
  end
endmodule
